/* sqs_query_set.v */
// Purpose: query/set command interpreter for the persistent settings table
// Assumes: one received byte per RX_VALID_IN pulse; TX_READY_IN from the sender
// Notes:   settings are stored in cells that keep their value across reset
`timescale 1ns/1ps
`include "sqs_map.vh"
module sqs_query_set #(
	parameter [7:0] REV_HIGH = 8'h31, // Arbitrary value
	parameter [7:0] REV_LOW  = 8'h32, // Arbitrary value
	parameter [7:0] SIG_GOOD = `SQS_RST_SIGNATURE
) (
	// Clock and reset
	input  wire        REF_CLK_IN,
	input  wire        SYS_RST_IN,
	// Received byte stream
	input  wire [7:0]  RX_DATA_IN,
	input  wire        RX_VALID_IN,
	// Reply byte stream
	output wire [7:0]  TX_DATA_OUT,
	output wire        TX_VALID_OUT,
	input  wire        TX_READY_IN,
	// Sprite size table access
	output wire [3:0]  SPRITE_INDEX_OUT,
	input  wire [7:0]  SPRITE_WIDTH_IN,
	input  wire [7:0]  SPRITE_HEIGHT_IN,
	// Settings in force
	output wire [17:0] LINE_BAUD_OUT,
	output wire [7:0]  LAMP_LEVEL_OUT,
	output wire [1:0]  STARTUP_PICTURE_OUT,
	output wire        DRAW_INVERTED_OUT,
	output wire        LINE_FEED_SAME_COLUMN_OUT,
	output wire [7:0]  RESUME_LEVEL_OUT,
	output wire [7:0]  PAUSE_LEVEL_OUT,
	output wire        PAGE_END_WRAP_OUT,
	output wire [7:0]  SCREEN_FORMAT_OUT,
	output wire [7:0]  GLYPH_SET_OUT,
	output wire        DEFAULTS_RESTORED_OUT
);
	// ************************************************************
	// States
	// ************************************************************
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_OPC   = 3'h1;
	localparam [2:0] ST_QID   = 3'h2;
	localparam [2:0] ST_CHK   = 3'h3;
	localparam [2:0] ST_SID   = 3'h4;
	localparam [2:0] ST_SVAL  = 3'h5;
	localparam [2:0] ST_TAG   = 3'h6;
	localparam [2:0] ST_BODY  = 3'h7;

	reg  [2:0] state_r;
	reg  [2:0] state_nxt;
	reg  [7:0] id_r;
	reg  [7:0] id_nxt;
	reg        drop_r;
	reg        drop_nxt;
	reg  [2:0] cnt_r;
	reg  [2:0] cnt_nxt;
	reg  [7:0] tx_r;
	reg  [7:0] tx_nxt;
	reg  [7:0] val_r;
	reg  [7:0] val_nxt;
	reg        text_r;
	reg        text_nxt;
	reg        wr_go;
	reg        restore_r;

	// ************************************************************
	// Settings cells
	// ************************************************************
	wire [7:0]  live [0:11];
	wire [7:0]  boot [0:11];
	wire [11:0] wr_sel;
	wire [7:0]  cell_rst [0:11];

	assign cell_rst[0]  = `SQS_RST_SIGNATURE;
	assign cell_rst[1]  = `SQS_RST_SPEED;
	assign cell_rst[2]  = `SQS_RST_LAMP;
	assign cell_rst[3]  = `SQS_RST_PICTURE;
	assign cell_rst[4]  = `SQS_RST_INVERT;
	assign cell_rst[5]  = `SQS_RST_RESERVED;
	assign cell_rst[6]  = `SQS_RST_LINE_END;
	assign cell_rst[7]  = `SQS_RST_RESUME;
	assign cell_rst[8]  = `SQS_RST_PAUSE;
	assign cell_rst[9]  = `SQS_RST_PAGE_END;
	assign cell_rst[10] = `SQS_RST_FORMAT;
	assign cell_rst[11] = `SQS_RST_GLYPH;

	genvar g;
	generate
		for (g = 0; g < 12; g = g + 1) begin : g_cell
			// Only identities 0x00..0x0B are writable; the rest are read-only
			// A restore overrides a host write landing in the same cycle
			assign wr_sel[g] = wr_go && (id_r == g) || restore_r;
			sqs_setting_cell #(
				.RST_VAL (8'h00)
			) u_cell (
				.clk     (REF_CLK_IN),
				.rst     (SYS_RST_IN),
				.wr_en   (wr_sel[g]),
				.wr_data (restore_r ? cell_rst[g] : val_r),
				.live    (live[g]),
				.boot    (boot[g])
			);
		end
	endgenerate

	// ************************************************************
	// Defaults restore
	// ************************************************************
	// A corrupted signature restores defaults just after reset
	reg rst_d_r;
	always @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			rst_d_r   <= 1'b1;
			restore_r <= 1'b0;
		end else begin
			rst_d_r   <= 1'b0;
			restore_r <= rst_d_r && (live[0] != SIG_GOOD);
		end
	end
	reg restored_r;
	always @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			restored_r <= 1'b0;
		end else if (restore_r) begin
			restored_r <= 1'b1;
		end
	end
	assign DEFAULTS_RESTORED_OUT = restored_r;

	// ************************************************************
	// Settings in force
	// ************************************************************
	// Boot copies drive the settings that apply only after reset
	reg [17:0] baud;
	always @* begin
		case (boot[1])
			8'h01:   baud = 18'd4800;
			8'h02:   baud = 18'd9600;
			8'h03:   baud = 18'd19200;
			8'h04:   baud = 18'd38400;
			8'h05:   baud = 18'd57600;
			default: baud = 18'd115200;
		endcase
	end
	assign LINE_BAUD_OUT = baud;
	// Lamp levels above full scale are held at full; resume and pause levels pass through
	assign LAMP_LEVEL_OUT = (boot[2] > `SQS_LAMP_MAX) ? `SQS_LAMP_MAX : boot[2];
	assign STARTUP_PICTURE_OUT = (boot[3] > 8'h02) ? 2'h0 : boot[3][1:0];
	assign DRAW_INVERTED_OUT = (live[4] == 8'h00);
	assign LINE_FEED_SAME_COLUMN_OUT = (live[6] == 8'h01);
	assign RESUME_LEVEL_OUT = live[7];
	assign PAUSE_LEVEL_OUT = live[8];
	assign PAGE_END_WRAP_OUT = (live[9] == 8'h01);
	assign SCREEN_FORMAT_OUT = boot[10];
	assign GLYPH_SET_OUT = live[11];

	// ************************************************************
	// Query value lookup
	// ************************************************************
	assign SPRITE_INDEX_OUT = id_r[4:1];
	reg [7:0] lookup;
	always @* begin
		lookup = `SQS_UNKNOWN;
		// Reserved identity five is stored and read back through the case below
		if (id_r < `SQS_ID_TABLE_END && id_r != `SQS_ID_RESERVED) begin
			lookup = live[id_r[3:0]];
		end else if (id_r[7:5] == 3'h4) begin
			lookup = id_r[0] ? SPRITE_HEIGHT_IN : SPRITE_WIDTH_IN;
		end else begin
			case (id_r)
				`SQS_ID_RESERVED:   lookup = live[5];
				`SQS_ID_SSPR_BYTES: lookup = `SQS_SSPR_BYTES;
				`SQS_ID_SSPR_COUNT: lookup = `SQS_SSPR_COUNT;
				`SQS_ID_VSPR_BYTES: lookup = `SQS_VSPR_BYTES;
				`SQS_ID_VSPR_COUNT: lookup = `SQS_VSPR_COUNT;
				`SQS_ID_WIDTH:      lookup = `SQS_SCREEN_W;
				`SQS_ID_HEIGHT:     lookup = `SQS_SCREEN_H;
				default:            lookup = `SQS_UNKNOWN;
			endcase
		end
	end

	// ************************************************************
	// Version text
	// ************************************************************
	// Version text: major digit, '.', minor digit, zero
	reg [7:0] ver_char;
	always @* begin
		case (cnt_r)
			3'h0:    ver_char = REV_HIGH;
			3'h1:    ver_char = `SQS_CHAR_DOT;
			3'h2:    ver_char = REV_LOW;
			default: ver_char = 8'h00;
		endcase
	end

	// ************************************************************
	// Command sequencer
	// ************************************************************
	always @* begin
		state_nxt = state_r;
		id_nxt    = id_r;
		drop_nxt  = drop_r;
		cnt_nxt   = cnt_r;
		tx_nxt    = tx_r;
		val_nxt   = val_r;
		text_nxt  = text_r;
		case (state_r)
			ST_IDLE: begin
				if (RX_VALID_IN && RX_DATA_IN == `SQS_LEAD_BYTE) begin
					state_nxt = ST_OPC;
				end
			end
			ST_OPC: begin
				if (RX_VALID_IN) begin
					if (RX_DATA_IN == `SQS_OP_READ) begin
						state_nxt = ST_QID;
					end else if (RX_DATA_IN == `SQS_OP_WRITE) begin
						state_nxt = ST_CHK;
					// A repeated lead byte keeps waiting for the opcode
					end else if (RX_DATA_IN != `SQS_LEAD_BYTE) begin
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_QID: begin
				if (RX_VALID_IN) begin
					id_nxt    = RX_DATA_IN;
					text_nxt  = (RX_DATA_IN == `SQS_ID_REV_HIGH) ||
					            (RX_DATA_IN == `SQS_ID_REV_LOW);
					cnt_nxt   = 3'h0;
					tx_nxt    = `SQS_REPLY_TAG;
					state_nxt = ST_TAG;
				end
			end
			ST_CHK: begin
				if (RX_VALID_IN) begin
					drop_nxt  = (RX_DATA_IN != `SQS_CONFIRM);
					state_nxt = ST_SID;
				end
			end
			ST_SID: begin
				if (RX_VALID_IN) begin
					id_nxt    = RX_DATA_IN;
					state_nxt = ST_SVAL;
				end
			end
			ST_SVAL: begin
				if (RX_VALID_IN) begin
					val_nxt   = RX_DATA_IN;
					state_nxt = ST_IDLE;
				end
			end
			ST_TAG: begin
				// Received bytes are ignored while a reply is offered
				if (TX_READY_IN) begin
					tx_nxt    = text_r ? ver_char : lookup;
					state_nxt = ST_BODY;
				end
			end
			ST_BODY: begin
				if (TX_READY_IN) begin
					if (text_r && cnt_r < (`SQS_VER_LEN - 3'h1)) begin
						cnt_nxt = cnt_r + 3'h1;
						tx_nxt  = (cnt_r == 3'h0) ? `SQS_CHAR_DOT :
						          (cnt_r == 3'h1) ? REV_LOW : 8'h00;
					end else begin
						state_nxt = ST_IDLE;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// ************************************************************
	// Write commit
	// ************************************************************
	// Write commits one cycle after the value byte lands
	reg commit_r;
	always @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			commit_r <= 1'b0;
		end else begin
			commit_r <= (state_r == ST_SVAL) && RX_VALID_IN && !drop_r &&
			            (id_r < `SQS_ID_TABLE_END);
		end
	end
	always @* begin
		wr_go = commit_r;
	end

	// ************************************************************
	// State registers
	// ************************************************************
	always @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			state_r <= ST_IDLE;
			id_r    <= 8'h00;
			drop_r  <= 1'b0;
			cnt_r   <= 3'h0;
			tx_r    <= 8'h00;
			val_r   <= 8'h00;
			text_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			id_r    <= id_nxt;
			drop_r  <= drop_nxt;
			cnt_r   <= cnt_nxt;
			tx_r    <= tx_nxt;
			val_r   <= val_nxt;
			text_r  <= text_nxt;
		end
	end

	// ************************************************************
	// Reply outputs
	// ************************************************************
	// Valid is decoded from state, so it drops right after the last accept
	assign TX_DATA_OUT  = tx_r;
	assign TX_VALID_OUT = (state_r == ST_TAG) || (state_r == ST_BODY);
endmodule // sqs_query_set

/* sqs_map.vh */
// Purpose: constants for the settings query/set interpreter
// Assumes: byte-wide serial receive and transmit streams
// Notes:   identities, codes and reset values of the settings table
`ifndef SQS_MAP_VH
`define SQS_MAP_VH
`define SQS_LEAD_BYTE       8'h7C
`define SQS_OP_READ         8'h1E
`define SQS_OP_WRITE        8'h1B
`define SQS_CONFIRM         8'hC5
`define SQS_REPLY_TAG       8'h51
`define SQS_UNKNOWN         8'hFF
`define SQS_ID_SIGNATURE    8'h00
`define SQS_ID_SPEED        8'h01
`define SQS_ID_LAMP         8'h02
`define SQS_ID_PICTURE      8'h03
`define SQS_ID_INVERT       8'h04
`define SQS_ID_RESERVED     8'h05
`define SQS_ID_LINE_END     8'h06
`define SQS_ID_RESUME       8'h07
`define SQS_ID_PAUSE        8'h08
`define SQS_ID_PAGE_END     8'h09
`define SQS_ID_FORMAT       8'h0A
`define SQS_ID_GLYPH        8'h0B
`define SQS_ID_REV_HIGH     8'h20
`define SQS_ID_REV_LOW      8'h21
`define SQS_ID_SSPR_BYTES   8'h22
`define SQS_ID_SSPR_COUNT   8'h23
`define SQS_ID_VSPR_BYTES   8'h24
`define SQS_ID_VSPR_COUNT   8'h25
`define SQS_ID_WIDTH        8'h40
`define SQS_ID_HEIGHT       8'h41
`define SQS_ID_SPRITE0_W    8'h80
`define SQS_ID_SPRITE0_H    8'h81
`define SQS_RST_SIGNATURE   8'hA5
`define SQS_RST_SPEED       8'h06
`define SQS_RST_LAMP        8'h64
`define SQS_RST_PICTURE     8'h01
`define SQS_RST_INVERT      8'h01
`define SQS_RST_LINE_END    8'h00
`define SQS_RST_RESUME      8'h14
`define SQS_RST_PAUSE       8'hA6
`define SQS_RST_PAGE_END    8'h00
`define SQS_RST_FORMAT      8'h00
`define SQS_RST_GLYPH       8'h00
`define SQS_LAMP_MAX        8'h64
`define SQS_SPEED_MIN       8'h01
`define SQS_SPEED_MAX       8'h06
`define SQS_SSPR_BYTES      8'h22
`define SQS_SSPR_COUNT      8'h0E
`define SQS_VSPR_BYTES      8'h22
`define SQS_VSPR_COUNT      8'h06
`define SQS_SCREEN_W        8'h80
`define SQS_SCREEN_H        8'h40
`define SQS_VER_LEN         3'h4
`define SQS_RST_RESERVED    8'h00
`define SQS_ID_TABLE_END    8'h0C
`define SQS_CHAR_DOT        8'h2E
`define SQS_BOOT_WINDOW     3'h7
`endif

/* sqs_setting_cell.v */
// Purpose: one persistent setting byte with a shadow taken at reset
// Assumes: write strobe from the interpreter on the same clock
// Notes:   live value changes at once; boot value only at reset
`timescale 1ns/1ps
`include "sqs_map.vh"
module sqs_setting_cell #(
	parameter [7:0] RST_VAL = 8'h00
) (
	input  wire       clk,
	input  wire       rst,
	input  wire       wr_en,
	input  wire [7:0] wr_data,
	output wire [7:0] live,
	output wire [7:0] boot
);
	reg [7:0] live_r;
	reg [7:0] boot_r;
	reg [2:0] load_r;

	// Boot copy follows the stored value for three cycles after reset, so it
	// also takes the defaults that a restore writes in the second cycle
	always @(posedge clk) begin
		if (rst) begin
			load_r <= `SQS_BOOT_WINDOW;
		end else begin
			load_r <= {load_r[1:0], 1'b0};
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			boot_r <= RST_VAL;
		end else if (load_r[2]) begin
			boot_r <= live_r;
		end
	end

	// Stored value survives the controller reset, as persistent memory does
	always @(posedge clk) begin
		if (wr_en) begin
			live_r <= wr_data;
		end
	end

	initial live_r = RST_VAL;

	assign live = live_r;
	assign boot = boot_r;
endmodule // sqs_setting_cell

/* sqs_query_set_checker.sv */
// Purpose: port checks on the settings query/set interpreter
// Assumes: host sends one byte every second cycle
// Notes:   bound to the design from the bench
`timescale 1ns/1ps
module sqs_query_set_checker (
	input wire       REF_CLK_IN,
	input wire       SYS_RST_IN,
	input wire [7:0] RX_DATA_IN,
	input wire       RX_VALID_IN,
	input wire [7:0] TX_DATA_OUT,
	input wire       TX_VALID_OUT,
	input wire       TX_READY_IN,
	input wire [3:0] SPRITE_INDEX_OUT,
	input wire [7:0] SPRITE_WIDTH_IN,
	input wire [7:0] SPRITE_HEIGHT_IN,
	input wire [7:0] LAMP_LEVEL_OUT,
	input wire       DRAW_INVERTED_OUT,
	input wire [7:0] RESUME_LEVEL_OUT
);
	// ****
	// Reply byte count and last identity
	// ****
	logic [2:0] cnt_r;
	logic [7:0] id_r;
	wire        ver = id_r[7:1] == 7'h10;
	wire        known = id_r < 8'h0C || (id_r > 8'h1F && id_r < 8'h26)
		|| id_r[7:1] == 7'h20 || id_r[7:5] == 3'h4;
	always @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN || !TX_VALID_OUT) begin
			cnt_r <= 3'h0;
		end else if (TX_READY_IN) begin
			cnt_r <= cnt_r + 3'h1;
		end
		if (RX_VALID_IN && !TX_VALID_OUT) begin
			id_r <= RX_DATA_IN;
		end
	end
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	sequence s_byte(b); RX_VALID_IN && RX_DATA_IN == b; endsequence
	sequence s_lead(op); s_byte(8'h7C) ##2 s_byte(op); endsequence
	sequence s_set(id); s_lead(8'h1B) ##2 s_byte(8'hC5) ##2 s_byte(id) ##2 RX_VALID_IN; endsequence
	// ****
	// Assertions
	// ****
	a_tag_first: assert property (TX_VALID_OUT && cnt_r == 3'h0 |-> TX_DATA_OUT == 8'h51)
		else $error("reply does not open with the tag");
	a_reply_holds: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
		else $error("reply byte dropped before acceptance");
	a_single_value: assert property (TX_VALID_OUT && TX_READY_IN && cnt_r == 3'h1 && !ver |=> !TX_VALID_OUT)
		else $error("more than one value byte");
	a_unknown_ones: assert property (TX_VALID_OUT && cnt_r == 3'h1 && !known |-> TX_DATA_OUT == 8'hFF)
		else $error("unknown identity not all ones");
	a_version_end: assert property (TX_VALID_OUT && cnt_r == 3'h4 |-> ver && TX_DATA_OUT == 8'h00)
		else $error("version text not zero terminated");
	a_screen_size: assert property (TX_VALID_OUT && cnt_r == 3'h1 && id_r[7:1] == 7'h20
		|-> TX_DATA_OUT == (id_r[0] ? 8'h40 : 8'h80))
		else $error("screen size answer wrong");
	a_sprite_pair: assert property (TX_VALID_OUT && cnt_r == 3'h1 && id_r[7:5] == 3'h4
		|-> SPRITE_INDEX_OUT == id_r[4:1]
		&& TX_DATA_OUT == (id_r[0] ? SPRITE_HEIGHT_IN : SPRITE_WIDTH_IN))
		else $error("sprite size answer wrong");
	a_invert_live: assert property (s_set(8'h04) |-> ##3 DRAW_INVERTED_OUT == ($past(RX_DATA_IN, 3) == 8'h00))
		else $error("inversion not applied at once");
	a_check_guard: assert property (s_lead(8'h1B) ##2 RX_VALID_IN && RX_DATA_IN != 8'hC5
		|=> $stable(RESUME_LEVEL_OUT) [*8])
		else $error("unconfirmed write took effect");
	a_lamp_deferred: assert property (s_set(8'h02) |=> $stable(LAMP_LEVEL_OUT) [*6])
		else $error("lamp level changed before reset");
endmodule // sqs_query_set_checker

/* sqs_host_model.sv */
// Purpose: host side of the serial command link
// Assumes: bytes sent every second cycle on the falling edge
// Notes:   collects accepted reply bytes in got
`timescale 1ns/1ps
module sqs_host_model (
	input  wire        clk,
	input  wire  [7:0] tx_data,
	input  wire        tx_valid,
	output logic       tx_ready,
	output logic [7:0] rx_data,
	output logic       rx_valid
);
	bit         slow = 0;
	int         ph = 0;
	logic [7:0] got[$];
	initial begin
		tx_ready = 1'b0;
		rx_data = 8'h00;
		rx_valid = 1'b0;
	end
	// Slow mode stalls the reply stream two cycles in three
	always @(negedge clk) begin
		ph <= ph + 1;
		tx_ready <= !slow || ph % 3 == 2;
	end
	always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
	// Idle data line shows the inverse of the last byte
	task automatic put(input logic [7:0] b);
		@(negedge clk);
		rx_data = b;
		rx_valid = 1'b1;
		@(negedge clk);
		rx_valid = 1'b0;
		rx_data = ~b;
	endtask
	task automatic query(input logic [7:0] id);
		put(8'h7C);
		put(8'h1E);
		put(id);
	endtask
	task automatic set(input logic [7:0] id, input logic [7:0] v);
		put(8'h7C);
		put(8'h1B);
		put(8'hC5);
		put(id);
		put(v);
		repeat (3) @(negedge clk);
	endtask
endmodule // sqs_host_model

/* serial_settings_query_set_bench.sv */
// Purpose: self-checking bench for the settings interpreter
// Assumes: host model sends commands and collects replies
// Notes:   the bench also serves the sprite size table
`timescale 1ns/1ps
module serial_settings_query_set_bench;
	localparam [7:0] RH = 8'h33; // Arbitrary revision value
	localparam [7:0] RL = 8'h39; // Arbitrary revision value
	logic        clk = 0;
	logic        rst = 1;
	wire  [7:0]  rxd, txd, lamp, resume, pause, fmt, glyph;
	wire         rxv, txv, txr, inv, lf, wrap, restored;
	wire  [3:0]  idx;
	wire  [17:0] baud;
	wire  [1:0]  pic;
	int          n_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          bauds[1:6] = '{4800, 9600, 19200, 38400, 57600, 115200};
	logic [7:0]  unk[4] = '{8'h0C, 8'h26, 8'h42, 8'hA0};
	logic [7:0]  bad[5] = '{8'h7C, 8'h1B, 8'hC4, 8'h07, 8'h44};
	sqs_query_set #(.REV_HIGH(RH), .REV_LOW(RL)) dut_u (
		.REF_CLK_IN(clk), .SYS_RST_IN(rst), .RX_DATA_IN(rxd), .RX_VALID_IN(rxv),
		.TX_DATA_OUT(txd), .TX_VALID_OUT(txv), .TX_READY_IN(txr), .SPRITE_INDEX_OUT(idx),
		.SPRITE_WIDTH_IN({4'hA, idx}), .SPRITE_HEIGHT_IN({4'hB, idx}),
		.LINE_BAUD_OUT(baud), .LAMP_LEVEL_OUT(lamp), .STARTUP_PICTURE_OUT(pic),
		.DRAW_INVERTED_OUT(inv), .LINE_FEED_SAME_COLUMN_OUT(lf), .RESUME_LEVEL_OUT(resume),
		.PAUSE_LEVEL_OUT(pause), .PAGE_END_WRAP_OUT(wrap), .SCREEN_FORMAT_OUT(fmt),
		.GLYPH_SET_OUT(glyph), .DEFAULTS_RESTORED_OUT(restored));
	sqs_host_model host_u (.clk(clk), .tx_data(txd), .tx_valid(txv), .tx_ready(txr),
		.rx_data(rxd), .rx_valid(rxv));
	always #20 clk = ~clk;
	// ****
	// Checking and closing
	// ****
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	task automatic reply(input logic [7:0] id, input logic [7:0] e[$]);
		int k;
		host_u.got.delete();
		host_u.query(id);
		for (k = 0; k < 90 && host_u.got.size() < e.size(); k++) @(negedge clk);
		repeat (6) @(negedge clk);
		check(host_u.got.size(), e.size());
		foreach (e[i]) check(host_u.got[i], e[i]);
	endtask
	task automatic ask(input logic [7:0] id, input logic [7:0] v);
		reply(id, {8'h51, v});
	endtask
	task pulse;
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		repeat (5) @(negedge clk);
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		pulse;
		check(restored, 1);
		check(lamp, 8'h64);
		check(baud, 115200);
		check(pic, 2'h1);
		check(inv, 0);
		check(resume, 8'h14);
		check(pause, 8'hA6);
		check(fmt, 8'h00);
		check(glyph, 8'h00);
		foreach (unk[i]) ask(unk[i], 8'hFF);
		ask(8'h40, 8'h80);
		ask(8'h41, 8'h40);
		host_u.slow = 1;
		ask(8'h80, 8'hA0);
		ask(8'h87, 8'hB3);
		ask(8'h9E, 8'hAF);
		reply(8'h20, {8'h51, RH, 8'h2E, RL, 8'h00});
		reply(8'h21, {8'h51, RH, 8'h2E, RL, 8'h00});
		host_u.slow = 0;
		host_u.set(8'h04, 8'h00);
		check(inv, 1);
		ask(8'h04, 8'h00);
		host_u.set(8'h06, 8'h01);
		check(lf, 1);
		host_u.set(8'h09, 8'h01);
		check(wrap, 1);
		host_u.set(8'h0B, 8'h01);
		check(glyph, 8'h01);
		host_u.set(8'h0A, 8'h08);
		check(fmt, 8'h00);
		host_u.set(8'h07, 8'h33);
		host_u.set(8'h08, 8'h99);
		check(resume, 8'h33);
		check(pause, 8'h99);
		host_u.set(8'h05, 8'h5A);
		ask(8'h05, 8'h5A);
		foreach (bad[i]) host_u.put(bad[i]);
		repeat (4) @(negedge clk);
		check(resume, 8'h33);
		host_u.set(8'h40, 8'h11);
		host_u.set(8'h22, 8'h01);
		ask(8'h40, 8'h80);
		ask(8'h22, 8'h22);
		host_u.set(8'h02, 8'h32);
		host_u.set(8'h03, 8'h02);
		check(lamp, 8'h64);
		check(pic, 2'h1);
		ask(8'h02, 8'h32);
		pulse;
		check(lamp, 8'h32);
		check(pic, 2'h2);
		check(restored, 0);
		check(fmt, 8'h08);
		check(glyph, 8'h01);
		for (int k = 1; k <= 6; k++) begin
			host_u.set(8'h01, k[7:0]);
			pulse;
			check(baud, bauds[k]);
		end
		host_u.set(8'h02, 8'h00);
		host_u.set(8'h03, 8'h00);
		pulse;
		check(lamp, 8'h00);
		check(pic, 2'h0);
		host_u.set(8'h00, 8'h00);
		pulse;
		check(restored, 1);
		check(lamp, 8'h64);
		check(resume, 8'h14);
		check(fmt, 8'h00);
		check(glyph, 8'h00);
		tally_and_finish;
	end
endmodule // serial_settings_query_set_bench
bind sqs_query_set sqs_query_set_checker chk_u (.REF_CLK_IN, .SYS_RST_IN, .RX_DATA_IN,
	.RX_VALID_IN, .TX_DATA_OUT, .TX_VALID_OUT, .TX_READY_IN, .SPRITE_INDEX_OUT,
	.SPRITE_WIDTH_IN, .SPRITE_HEIGHT_IN, .LAMP_LEVEL_OUT, .DRAW_INVERTED_OUT,
	.RESUME_LEVEL_OUT);
